// *** bsp_host.sv ***
/*
  Host controller model: makes the input strobe pair and issues bursts.
  Assumes ref_clk is the bench clock; the strobes run at 1/16 of it.
*/
`timescale 1ns/10ps
module bsp_host
  import bsp_pkg::*;
(
  input  logic                  ref_clk,
  input  logic                  single,
  output logic                  strobe_k,
  output logic                  strobe_k_n,
  output logic                  out_strobe_c,
  output logic                  out_strobe_c_n,
  output logic                  read_sel_n,
  output logic                  write_sel_n,
  output logic [LOC_W-1:0]      location_bus,
  output logic [PIN_DATA_W-1:0] write_beats_in,
  output logic [LANES_WIDE-1:0] lane_mask_n,
  input  logic [PIN_DATA_W-1:0] read_beats_out,
  input  logic [PIN_DATA_W-1:0] read_beats_oe,
  input  logic                  returned_strobe_pos,
  input  logic                  returned_strobe_neg
);
  logic [3:0] ph = 4'h0;

  always @(negedge ref_clk)
  begin
    ph <= ph + 4'h1;
  end
  assign strobe_k       = ~ph[3];
  assign strobe_k_n     = ph[3];
  // c pair tracks k with no skew while single is low; single forces both high; the latency count relies on it
  assign out_strobe_c   = single | strobe_k;
  assign out_strobe_c_n = single | strobe_k_n;

  initial
  begin
    read_sel_n     = 1'b1;
    write_sel_n    = 1'b1;
    location_bus   = 18'h0;
    write_beats_in = 36'h0;
    lane_mask_n    = 4'hf;
  end

  // returns at the falling edge where ph takes the value p
  task automatic at(input logic [3:0] p);
    do
      @(negedge ref_clk);
    while (ph != p - 4'h1);
  endtask : at

  // pins change mid phase, so setup and hold sit around each rise
  task automatic wr(input logic [LOC_W-1:0] a, input logic [143:0] d,
                    input logic [15:0] m);
    at(4'hc);
    write_sel_n  = 1'b0;
    location_bus = a;
    at(4'h4);
    write_sel_n  = 1'b1;
    location_bus = ~a;
    for (int i = 0; i < 4; i++)
    begin
      at(i[0] ? 4'h4 : 4'hc);
      write_beats_in = d[36*i +: 36];
      lane_mask_n    = m[4*i +: 4];
    end
    at(4'hc);
    write_beats_in = ~write_beats_in;
    lane_mask_n    = 4'hf;
  endtask : wr

  // blocking capture keeps commands at least two strobe cycles apart
  task automatic rd(input logic [LOC_W-1:0] a, output int lat,
                    output logic [143:0] q, output logic [1:0] echo,
                    output logic [71:0] oe);
    lat = 0;
    at(4'hc);
    read_sel_n   = 1'b0;
    location_bus = a;
    at(4'h0);
    while (read_beats_oe === 36'h0 && lat < 60)
    begin
      @(negedge ref_clk);
      lat++;
      if (lat == 4)
      begin
        read_sel_n   = 1'b1;
        location_bus = ~a;
      end
    end
    echo      = {returned_strobe_pos, returned_strobe_neg};
    oe[71:36] = read_beats_oe;
    for (int k = 0; k < 4; k++)
    begin
      repeat (k == 0 ? 4 : 8) @(negedge ref_clk);
      q[36*k +: 36] = read_beats_out;
    end
    repeat (8) @(negedge ref_clk);
    oe[35:0] = read_beats_oe;
  endtask : rd
endmodule : bsp_host

// *** bsp_mem.sv ***
/*
  Byte-lane writable storage array with a registered read port.
  Assumes one clock; write and read addresses come from the same domain.
*/
`timescale 1ns/10ps
module bsp_mem
#(
  parameter int AW    = 20,
  parameter int LANES = 4,
  parameter int BW    = 9
)(
  input  wire logic                clk,
  input  wire logic                we,
  input  wire logic [AW-1:0]       waddr,
  input  wire logic [LANES*BW-1:0] wdata,
  input  wire logic [LANES-1:0]    lane_en,
  input  wire logic [AW-1:0]       raddr,
  output logic      [LANES*BW-1:0] rdata_r
);
  logic [LANES*BW-1:0] cell_r [2**AW];

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (we && lane_en[i])
        cell_r[waddr][i*BW +: BW] <= wdata[i*BW +: BW];
    end
  end

  // read every cycle; the caller samples only when it needs the word
  always_ff @(posedge clk)
  begin
    rdata_r <= cell_r[raddr];
  end
endmodule : bsp_mem

// *** bsp_pkg.sv ***
/*
  Shared constants and types for the burst-of-four SRAM port model.
  Assumes every consumer imports the whole package.
*/
package bsp_pkg;
  localparam int BYTE_W           = 9;
  localparam int LANES_WIDE       = 4;
  localparam int LANES_NARROW     = 2;
  localparam int PIN_DATA_W       = BYTE_W * LANES_WIDE;
  localparam int LOC_W            = 18;
  localparam int BEAT_W           = 2;
  localparam int MEM_AW           = LOC_W + BEAT_W;
  localparam int STAMP_W          = 4;
  localparam int FIFO_DEPTH       = 2;
  localparam logic [STAMP_W-1:0] SKIP_DLL_ON  = 4'h3;
  localparam logic [STAMP_W-1:0] SKIP_DLL_OFF = 4'h2;
  localparam logic [BEAT_W-1:0]  FIRST_BEAT   = 2'h0;
  localparam logic [BEAT_W-1:0]  MID_BEAT     = 2'h2;
  localparam logic [BEAT_W-1:0]  LAST_BEAT    = 2'h3;
  localparam int LOCK_KCYC        = 1024;
  localparam int LOCK_CNT_W       = 11;
  localparam int DLL_OFF_FMAX_MHZ = 167;
  localparam int REF_CLK_MHZ      = 100;

  typedef struct packed {
    logic                  k;
    logic                  k_n;
    logic                  c;
    logic                  c_n;
    logic                  dll_on;
    logic                  rd_n;
    logic                  wr_n;
    logic [LOC_W-1:0]      loc;
    logic [PIN_DATA_W-1:0] wdata;
    logic [LANES_WIDE-1:0] mask_n;
  } bsp_pins_t;

  typedef struct packed {
    logic [LOC_W-1:0]   loc;
    logic [STAMP_W-1:0] stamp;
  } bsp_rd_req_t;

  typedef struct packed {
    logic                  we;
    logic [MEM_AW-1:0]     addr;
    logic [PIN_DATA_W-1:0] data;
    logic [LANES_WIDE-1:0] lane_en;
  } bsp_wr_t;

  typedef enum {RD_IDLE, RD_BURST} bsp_rd_state_t;
  typedef enum {WR_IDLE, WR_BEATS} bsp_wr_state_t;
endpackage : bsp_pkg

// *** bsp_sram_port.sv ***
/*
  Pin-level model of a burst-of-four SRAM with separate read and write
  buses, oversampling the link strobes with ref_clk.
  Assumes all link pins are asynchronous to ref_clk and that ref_clk runs
  at least eight times faster than the input strobe.
*/
// Notes on behaviour
// - address and commands on true strobe rise; write data on both rises.
// - read beats launch on rising edges of the output timing pair.
// - both output strobes high selects input pair; reads only drive bus.
// - returned strobes toggle always, aligned to read beats.
// - dll input low bypasses dll and drops lock state.
// - dll input high runs dll; lock only after the lock interval.
// - dll off gives one-cycle read latency; controller keeps low rate.
// - address taken on true rise, ignored when no read or write.
// - narrow build uses write bits 0..17, wide uses 0..35.
// - narrow build drives read bits 0..17, wide drives 0..35.
// - low write select at true rise registers address, starts write.
// - low read select at true rise registers address, starts read.
// - lane mask sampled with its beat; low mask stores that byte.
// - recent writes are visible to following reads.
// - an idle read select never cuts a running read burst.
`timescale 1ns/10ps
module bsp_sram_port
  import bsp_pkg::*;
#(
  parameter bit NARROW = 1'b0
)(
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic                  strobe_k,
  input  wire logic                  strobe_k_n,
  input  wire logic                  out_strobe_c,
  input  wire logic                  out_strobe_c_n,
  input  wire logic                  dll_enable,
  input  wire logic                  read_sel_n,
  input  wire logic                  write_sel_n,
  input  wire logic [LOC_W-1:0]      location_bus,
  input  wire logic [PIN_DATA_W-1:0] write_beats_in,
  input  wire logic [LANES_WIDE-1:0] lane_mask_n,
  output logic      [PIN_DATA_W-1:0] read_beats_out,
  output logic      [PIN_DATA_W-1:0] read_beats_oe,
  output logic                       returned_strobe_pos,
  output logic                       returned_strobe_neg,
  output logic                       dll_locked
);
  localparam int LANES = NARROW ? LANES_NARROW : LANES_WIDE;
  localparam logic [LANES_WIDE-1:0] LANE_MASK =
    LANES_WIDE'((1 << LANES) - 1);
  localparam logic [PIN_DATA_W-1:0] DATA_MASK =
    {PIN_DATA_W{1'b1}} >> ((LANES_WIDE - LANES) * BYTE_W);

  bsp_pins_t     pins_in;
  bsp_pins_t     pin_meta_r;
  bsp_pins_t     pin_r;
  logic          k_d_r;
  logic          kn_d_r;
  logic          tp_d_r;
  logic          tn_d_r;
  logic          single_clk;
  logic          tpos;
  logic          tneg;
  logic          k_rise;
  logic          kn_rise;
  logic          t_edge;
  logic [STAMP_W-1:0] edge_cnt_r;
  logic [STAMP_W-1:0] edge_cnt_nxt;
  logic [STAMP_W-1:0] skip;
  logic [LOCK_CNT_W-1:0] lock_cnt_r;
  logic          rd_cmd;
  logic          wr_cmd;
  bsp_rd_req_t   fifo_r [FIFO_DEPTH];
  logic          fifo_wp_r;
  logic          fifo_rp_r;
  logic [1:0]    fifo_cnt_r;
  logic          in_ready;
  logic          push;
  logic          out_valid;
  bsp_rd_req_t   head;
  logic          due;
  logic          start;
  bsp_rd_state_t rd_state_r;
  logic [LOC_W-1:0]  rd_loc_r;
  logic [BEAT_W-1:0] rd_beat_r;
  logic          drive_r;
  logic [PIN_DATA_W-1:0] q_r;
  logic [PIN_DATA_W-1:0] rdata;
  logic [MEM_AW-1:0]     raddr;
  bsp_wr_state_t wr_state_r;
  logic          wr_wait_r;
  logic [LOC_W-1:0]  wr_loc_q_r;
  logic [LOC_W-1:0]  wr_loc_r;
  logic [BEAT_W-1:0] wr_beat_r;
  bsp_wr_t       mem_wr;

  always_comb
  begin
    pins_in = '{k: strobe_k, k_n: strobe_k_n, c: out_strobe_c,
                c_n: out_strobe_c_n, dll_on: dll_enable,
                rd_n: read_sel_n, wr_n: write_sel_n, loc: location_bus,
                wdata: write_beats_in, mask_n: lane_mask_n};
  end

  // whole pin set crosses together so data stays aligned with its strobe
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_meta_r <= '0;
      pin_r      <= '0;
    end
    else
    begin
      pin_meta_r <= pins_in;
      pin_r      <= pin_meta_r;
    end
  end

  assign single_clk = pin_r.c & pin_r.c_n;
  assign tpos       = single_clk ? pin_r.k   : pin_r.c;
  assign tneg       = single_clk ? pin_r.k_n : pin_r.c_n;
  assign k_rise     = pin_r.k & ~k_d_r;
  assign kn_rise    = pin_r.k_n & ~kn_d_r;
  assign t_edge     = (tpos & ~tp_d_r) | (tneg & ~tn_d_r);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      k_d_r  <= 1'b0;
      kn_d_r <= 1'b0;
      tp_d_r <= 1'b0;
      tn_d_r <= 1'b0;
    end
    else
    begin
      k_d_r  <= pin_r.k;
      kn_d_r <= pin_r.k_n;
      tp_d_r <= tpos;
      tn_d_r <= tneg;
    end
  end

  // returned pair follows the launching pair, registered with the beats
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      returned_strobe_pos <= 1'b0;
      returned_strobe_neg <= 1'b0;
    end
    else
    begin
      returned_strobe_pos <= tpos;
      returned_strobe_neg <= tneg;
    end
  end

  // lock counted in input strobe cycles, not ref cycles
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lock_cnt_r <= '0;
      dll_locked <= 1'b0;
    end
    else if (!pin_r.dll_on)
    begin
      lock_cnt_r <= '0;
      dll_locked <= 1'b0;
    end
    else if (k_rise && !dll_locked)
    begin
      lock_cnt_r <= lock_cnt_r + 1'b1;
      dll_locked <= (lock_cnt_r == LOCK_CNT_W'(LOCK_KCYC - 1));
    end
  end

  // above DLL_OFF_FMAX_MHZ the bypass latency is the controller's problem
  assign skip = pin_r.dll_on ? SKIP_DLL_ON : SKIP_DLL_OFF;
  assign edge_cnt_nxt = edge_cnt_r + STAMP_W'(t_edge);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      edge_cnt_r <= '0;
    else
      edge_cnt_r <= edge_cnt_nxt;
  end

  assign rd_cmd = k_rise & ~pin_r.rd_n;
  assign wr_cmd = k_rise & ~pin_r.wr_n;

  // two-entry request buffer; a full buffer refuses the command
  assign in_ready  = (fifo_cnt_r != 2'(FIFO_DEPTH));
  assign push      = rd_cmd & in_ready;
  assign out_valid = (fifo_cnt_r != 2'h0);
  assign head      = fifo_r[fifo_rp_r];
  assign due   = out_valid && ((edge_cnt_nxt - head.stamp) == skip);
  assign start = t_edge && (rd_state_r == RD_IDLE) && due;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fifo_r     <= '{default: '0};
      fifo_wp_r  <= 1'b0;
      fifo_rp_r  <= 1'b0;
      fifo_cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        fifo_r[fifo_wp_r] <= '{loc: pin_r.loc, stamp: edge_cnt_nxt};
        fifo_wp_r         <= ~fifo_wp_r;
      end
      if (start)
        fifo_rp_r <= ~fifo_rp_r;
      fifo_cnt_r <= fifo_cnt_r + 2'(push) - 2'(start);
    end
  end

  assign raddr = (rd_state_r == RD_BURST) ? {rd_loc_r, rd_beat_r}
                                          : {head.loc, FIRST_BEAT};

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_state_r <= RD_IDLE;
      rd_loc_r   <= '0;
      rd_beat_r  <= FIRST_BEAT;
      drive_r    <= 1'b0;
      q_r        <= '0;
    end
    else if (t_edge)
    begin
      drive_r <= start | (rd_state_r == RD_BURST);
      case (rd_state_r)
        RD_IDLE:
        begin
          if (start)
          begin
            q_r        <= rdata;
            rd_loc_r   <= head.loc;
            rd_beat_r  <= FIRST_BEAT + 2'h1;
            rd_state_r <= RD_BURST;
          end
        end
        RD_BURST:
        begin
          // read select is not looked at here, so bursts always finish
          q_r       <= rdata;
          rd_beat_r <= rd_beat_r + 2'h1;
          if (rd_beat_r == LAST_BEAT)
            rd_state_r <= RD_IDLE;
        end
        default:
          rd_state_r <= RD_IDLE;
      endcase
    end
  end

  assign read_beats_out = q_r & DATA_MASK;
  assign read_beats_oe  = drive_r ? DATA_MASK : '0;

  // late write: address held one cycle, beats on K, K#, K, K#
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_state_r <= WR_IDLE;
      wr_wait_r  <= 1'b0;
      wr_loc_q_r <= '0;
      wr_loc_r   <= '0;
      wr_beat_r  <= FIRST_BEAT;
    end
    else if (k_rise)
    begin
      wr_wait_r <= wr_cmd;
      if (wr_cmd)
        wr_loc_q_r <= pin_r.loc;
      if (wr_wait_r)
      begin
        wr_loc_r   <= wr_loc_q_r;
        wr_beat_r  <= FIRST_BEAT + 2'h1;
        wr_state_r <= WR_BEATS;
      end
      else if (wr_state_r == WR_BEATS && wr_beat_r == MID_BEAT)
        wr_beat_r <= LAST_BEAT;
    end
    else if (kn_rise && wr_state_r == WR_BEATS && wr_beat_r[0])
    begin
      wr_beat_r <= wr_beat_r + 2'h1;
      if (wr_beat_r == LAST_BEAT)
        wr_state_r <= WR_IDLE;
    end
  end

  // write-through per beat keeps any later read coherent
  always_comb
  begin
    mem_wr.we = (k_rise && (wr_wait_r || (wr_state_r == WR_BEATS
                 && wr_beat_r == MID_BEAT)))
             || (kn_rise && wr_state_r == WR_BEATS && wr_beat_r[0]);
    mem_wr.addr = (k_rise && wr_wait_r) ? {wr_loc_q_r, FIRST_BEAT}
                                        : {wr_loc_r, wr_beat_r};
    mem_wr.data    = pin_r.wdata & DATA_MASK;
    mem_wr.lane_en = ~pin_r.mask_n & LANE_MASK;
  end

  bsp_mem #(
    .AW    (MEM_AW),
    .LANES (LANES_WIDE),
    .BW    (BYTE_W)
  ) i_bsp_mem (
    .clk     (ref_clk),
    .we      (mem_wr.we),
    .waddr   (mem_wr.addr),
    .wdata   (mem_wr.data),
    .lane_en (mem_wr.lane_en),
    .raddr   (raddr),
    .rdata_r (rdata)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence burst_start_s;
    start;
  endsequence

  sequence burst_hold_s;
    (rd_state_r == RD_BURST) [*8];
  endsequence

  beat_launch_a: assert property (burst_start_s |=> drive_r)
    else $error("read bus not driven after first beat");
  burst_hold_a: assert property (burst_start_s |=> burst_hold_s)
    else $error("read burst ended early");
  idle_quiet_a: assert property (
    (t_edge && !start && rd_state_r == RD_IDLE) |=> read_beats_oe == '0)
    else $error("read bus driven without a read");
  strobe_echo_a: assert property (
    single_clk |=> returned_strobe_pos == $past(pin_r.k))
    else $error("returned strobe not following input pair");
  dll_drop_a: assert property (!pin_r.dll_on |=> !dll_locked)
    else $error("lock kept with dll bypassed");
  lock_wait_a: assert property (
    $rose(pin_r.dll_on) |=> !dll_locked [*8])
    else $error("lock reached too early");
  read_latency_a: assert property (
    (rd_cmd && fifo_cnt_r == 2'h0 && rd_state_r == RD_IDLE)
    |-> ##[1:60] start)
    else $error("first read beat late");
  narrow_lane_a: assert property (
    mem_wr.we |-> (mem_wr.lane_en & ~LANE_MASK) == '0)
    else $error("unused lane written");
  write_edge_a: assert property (mem_wr.we |-> (k_rise || kn_rise))
    else $error("write away from a strobe edge");
  // a burst may still pop the buffer at a deselected edge; no push allowed
  deselect_a: assert property (
    (k_rise && pin_r.rd_n && pin_r.wr_n) |=> !wr_wait_r
    && ((fifo_cnt_r + 2'($past(start))) == $past(fifo_cnt_r)))
    else $error("address taken while deselected");
  write_start_a: assert property (wr_cmd |=> wr_wait_r)
    else $error("write command lost");
  read_take_a: assert property (
    (rd_cmd && fifo_cnt_r == 2'h0) |=> out_valid || start)
    else $error("read command lost");
endmodule : bsp_sram_port

// *** bsp_sram_port_tb_top.sv ***
/*
  Self-checking bench for the burst-of-four port, wide and narrow builds.
  Assumes bsp_host drives the link pins of both instances.
*/
`timescale 1ns/10ps
module bsp_sram_port_tb_top
  import bsp_pkg::*;
;
  localparam logic [143:0] PAT = 144'h0123456789abcdef0fedcba98765432110ab;
  logic                  ref_clk    = 1'b0;
  logic                  arst_n     = 1'b0;
  logic                  dll_enable = 1'b1;
  logic                  single     = 1'b0;
  logic                  strobe_k;
  logic                  strobe_k_n;
  logic                  out_strobe_c;
  logic                  out_strobe_c_n;
  logic                  read_sel_n;
  logic                  write_sel_n;
  logic [LOC_W-1:0]      location_bus;
  logic [PIN_DATA_W-1:0] write_beats_in;
  logic [LANES_WIDE-1:0] lane_mask_n;
  logic [PIN_DATA_W-1:0] read_beats_out;
  logic [PIN_DATA_W-1:0] read_beats_oe;
  logic                  returned_strobe_pos;
  logic                  returned_strobe_neg;
  logic                  dll_locked;
  logic [PIN_DATA_W-1:0] nrw_q;
  logic [PIN_DATA_W-1:0] nrw_oe;
  int                    mismatches = 0;
  int                    num_checks = 0;
  int                    cycles     = 0;

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  bsp_host i_bsp_host (.ref_clk, .single, .strobe_k, .strobe_k_n,
    .out_strobe_c, .out_strobe_c_n, .read_sel_n, .write_sel_n,
    .location_bus, .write_beats_in, .lane_mask_n, .read_beats_out,
    .read_beats_oe, .returned_strobe_pos, .returned_strobe_neg);

  bsp_sram_port #(.NARROW(1'b0)) i_bsp_sram_port (.ref_clk, .arst_n,
    .strobe_k, .strobe_k_n, .out_strobe_c, .out_strobe_c_n, .dll_enable,
    .read_sel_n, .write_sel_n, .location_bus, .write_beats_in,
    .lane_mask_n, .read_beats_out, .read_beats_oe, .returned_strobe_pos,
    .returned_strobe_neg, .dll_locked);

  bsp_sram_port #(.NARROW(1'b1)) i_bsp_sram_port_nrw (.ref_clk, .arst_n,
    .strobe_k, .strobe_k_n, .out_strobe_c, .out_strobe_c_n, .dll_enable,
    .read_sel_n, .write_sel_n, .location_bus, .write_beats_in,
    .lane_mask_n, .read_beats_out(nrw_q), .read_beats_oe(nrw_oe),
    .returned_strobe_pos(), .returned_strobe_neg(), .dll_locked());

  task automatic chk(input logic [143:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  // narrow build shadows the wide one; its upper half must stay dark
  always @(negedge ref_clk)
  begin
    if (nrw_oe !== 36'h0)
    begin
      chk(nrw_oe, 36'h3ffff, "narrow oe");
      chk(nrw_q, {18'h0, read_beats_out[17:0]}, "narrow data");
    end
  end

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic t_idle;
    int   n;
    logic p;
    n = 0;
    chk(read_beats_oe, 0, "idle oe");
    chk(dll_locked, 0, "lock at start");
    p = returned_strobe_pos;
    repeat (32)
    begin
      @(negedge ref_clk);
      if (returned_strobe_pos !== p)
        n++;
      p = returned_strobe_pos;
    end
    chk(n, 4, "echo toggles while idle");
    $display("t_idle done");
  endtask : t_idle

  task automatic t_rw;
    int           lat;
    logic [143:0] q;
    logic [1:0]   echo;
    logic [71:0]  oe;
    for (int s = 0; s < 2; s++)
    begin
      single = s[0];
      i_bsp_host.wr({17'h1ffff, s[0]}, PAT, 16'h0000);
      i_bsp_host.rd({17'h1ffff, s[0]}, lat, q, echo, oe);
      chk(q, PAT, "burst data");
      chk(lat >= 26 && lat <= 30, 1, "dll on latency");
      chk(echo, 2'b01, "echo at first beat");
      chk(oe, {36'hfffffffff, 36'h0}, "drive window");
    end
    single = 1'b0;
    $display("t_rw done");
  endtask : t_rw

  task automatic t_mask;
    int           lat;
    logic [143:0] q;
    logic [143:0] e;
    logic [1:0]   echo;
    logic [71:0]  oe;
    e = PAT;
    for (int i = 0; i < 4; i++)
      e[45*i +: 9] = ~e[45*i +: 9];
    i_bsp_host.wr(18'h00010, PAT, 16'h0000);
    i_bsp_host.wr(18'h00010, ~PAT, 16'h7bde);
    i_bsp_host.rd(18'h00010, lat, q, echo, oe);
    chk(q, e, "masked burst");
    $display("t_mask done");
  endtask : t_mask

  task automatic t_dll_off;
    int           lat;
    logic [143:0] q;
    logic [1:0]   echo;
    logic [71:0]  oe;
    dll_enable = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(dll_locked, 0, "lock while bypassed");
    i_bsp_host.wr(18'h00a5a, ~PAT, 16'h0000);
    i_bsp_host.rd(18'h00a5a, lat, q, echo, oe);
    chk(q, ~PAT, "bypass data");
    chk(lat >= 18 && lat <= 22, 1, "bypass latency");
    chk(echo, 2'b10, "bypass echo");
    $display("t_dll_off done");
  endtask : t_dll_off

  task automatic t_lock;
    dll_enable = 1'b1;
    repeat ((LOCK_KCYC - 24) * 16) @(negedge ref_clk);
    chk(dll_locked, 0, "lock too early");
    repeat (40 * 16) @(negedge ref_clk);
    chk(dll_locked, 1, "lock after interval");
    dll_enable = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(dll_locked, 0, "lock dropped");
    dll_enable = 1'b1;
    repeat (100 * 16) @(negedge ref_clk);
    chk(dll_locked, 0, "lock restarts from zero");
    $display("t_lock done");
  endtask : t_lock

  initial
  begin
    repeat (6) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    t_idle();
    t_rw();
    t_mask();
    t_dll_off();
    t_lock();
    test_done();
  end
endmodule : bsp_sram_port_tb_top
